/* rtl/mfit_interval_div.sv */
`timescale 1ns/1ps
`include "mfit_params.svh"

module mfit_interval_div #(
  parameter int CNT_W = `MFIT_TB_CNT_W
) (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       nrst,
  // control
  input  wire logic       run,
  input  wire logic       tick,
  input  wire logic [2:0] period0,
  input  wire logic [1:0] period1,
  // overflow pulses
  output logic            ovf0,
  output logic            ovf1
);

  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic [CNT_W-1:0] mask0;
  logic [CNT_W-1:0] mask1;
  logic             next_ovf0;
  logic             next_ovf1;

  // ---------------------------------------------------------------------------
  // shared divider: both periods are powers of two, so one counter serves both
  // ---------------------------------------------------------------------------
  always_comb
  begin
    mask0     = CNT_W'((1 << (`MFIT_TB0_BASE_LOG2 + 32'(period0))) - 1);
    mask1     = CNT_W'((1 << (`MFIT_TB1_BASE_LOG2 + 32'(period1))) - 1);
    next_cnt  = cnt;
    next_ovf0 = 1'b0;
    next_ovf1 = 1'b0;
    if (!run)
      next_cnt = '0;
    else if (tick)
    begin
      next_cnt  = cnt + CNT_W'(1);
      next_ovf0 = (next_cnt & mask0) == '0;
      next_ovf1 = (next_cnt & mask1) == '0;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      cnt  <= '0;
      ovf0 <= 1'b0;
      ovf1 <= 1'b0;
    end
    else
    begin
      cnt  <= next_cnt;
      ovf0 <= next_ovf0;
      ovf1 <= next_ovf1;
    end
  end

  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  property p_stopped_quiet;
    @(posedge ref_clk) disable iff (!nrst)
    (!run ##1 !run) |-> (!ovf0 && !ovf1);
  endproperty
  a_stopped_quiet: assert property (p_stopped_quiet)
    else $error("interval divider overflowed while stopped");

endmodule : mfit_interval_div

/* rtl/mfit_irq_top.sv */
`timescale 1ns/1ps
`include "mfit_params.svh"


module mfit_irq_top #(
  parameter logic [7:0] VEC_TB0_ADDR = 8'h1C,
  parameter logic [7:0] VEC_TB1_ADDR = 8'h20
) (
  // clock and reset
  input  wire logic               ref_clk,
  input  wire logic               nrst,
  // register port
  input  wire logic [7:0]         addr,
  input  wire logic [7:0]         wr_data,
  input  wire logic               wr_en,
  input  wire logic               rd_en,
  output logic      [7:0]         rd_data,
  // on-chip sources
  input  wire mfit_pkg::mfit_src_s src,
  input  wire logic               interval_clock,
  // core interrupt sequencing
  input  wire logic               stack_full,
  input  wire logic               irq_ack,
  input  wire logic               halted,
  output logic                    irq_req,
  output logic      [7:0]         irq_addr,
  output logic                    wake_req,
  // oscillator control
  output logic                    slow_crystal_low_power
);

  // ---------------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------------
  logic [7:0]          timebase_control;
  logic                global_irq_enable;
  logic                grouped_irq_enable;
  logic                interval0_enable;
  logic                interval1_enable;
  logic                grouped_irq_flag;
  logic                interval0_flag;
  logic                interval1_flag;
  mfit_pkg::mfit_sub_s sub_en;
  mfit_pkg::mfit_sub_s sub_flag;
  mfit_pkg::mfit_vec_e irq_vec;
  logic                periph_prev;
  logic [1:0]          cmp_prev;
  logic                ick_prev;
  logic [1:0]          pre_cnt;

  logic [7:0]          next_timebase_control;
  logic                next_global_irq_enable;
  logic                next_grouped_irq_enable;
  logic                next_interval0_enable;
  logic                next_interval1_enable;
  logic                next_grouped_irq_flag;
  logic                next_interval0_flag;
  logic                next_interval1_flag;
  mfit_pkg::mfit_sub_s next_sub_en;
  mfit_pkg::mfit_sub_s next_sub_flag;
  mfit_pkg::mfit_vec_e next_irq_vec;
  logic                next_irq_req;
  logic [7:0]          next_irq_addr;
  logic                next_wake_req;
  logic [7:0]          next_rd_data;
  logic [1:0]          next_pre_cnt;

  logic                tb_tick;
  logic                ovf0;
  logic                ovf1;
  mfit_pkg::mfit_sub_s ev_sub;
  logic                grp_ev;
  logic                took;
  logic                pend_grp;
  logic                pend_tb0;
  logic                pend_tb1;
  logic [7:0]          old_flags;
  logic [7:0]          new_flags;

  // ---------------------------------------------------------------------------
  // interval clock source and divider
  // ---------------------------------------------------------------------------
  // dedicated clock is an ordinary synchronous input, counted on its rising edge
  always_comb
  begin
    next_pre_cnt = pre_cnt + 2'd1;
    if (timebase_control[`MFIT_TBC_CKSEL])
      tb_tick = pre_cnt == 2'(`MFIT_SYS_DIV - 1);
    else
      tb_tick = interval_clock && !ick_prev;
  end

  mfit_interval_div u_div (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .run     (timebase_control[`MFIT_TBC_RUN]),
    .tick    (tb_tick),
    .period0 (timebase_control[`MFIT_TBC_P0_HI:`MFIT_TBC_P0_LO]),
    .period1 (timebase_control[`MFIT_TBC_P1_HI:`MFIT_TBC_P1_LO]),
    .ovf0    (ovf0),
    .ovf1    (ovf1)
  );

  // ---------------------------------------------------------------------------
  // source events
  // ---------------------------------------------------------------------------
  always_comb
  begin
    ev_sub              = '0;
    ev_sub.conv_done    = src.conv_done;
    ev_sub.periph_edge  = periph_prev && !src.periph_edge_input;
    ev_sub.comparator   = |(cmp_prev ^ src.comparator_out);
    ev_sub.memory_cycle = src.memory_cycle_done;
    ev_sub.low_supply   = src.low_supply;
    // only enabled sub-sources reach the grouped flag
    grp_ev              = |(ev_sub & sub_en);
  end

  // ---------------------------------------------------------------------------
  // flags, enables and service clears
  // ---------------------------------------------------------------------------
  // hardware sets win over a software write or an automatic clear
  always_comb
  begin
    took                    = irq_req && irq_ack;
    next_timebase_control   = timebase_control;
    next_global_irq_enable  = global_irq_enable;
    next_grouped_irq_enable = grouped_irq_enable;
    next_interval0_enable   = interval0_enable;
    next_interval1_enable   = interval1_enable;
    next_grouped_irq_flag   = grouped_irq_flag;
    next_interval0_flag     = interval0_flag;
    next_interval1_flag     = interval1_flag;
    next_sub_en             = sub_en;
    next_sub_flag           = sub_flag;
    if (wr_en)
    begin
      unique case (addr)
        `MFIT_OFS_TBCTRL:  next_timebase_control = wr_data;
        `MFIT_OFS_IRQCTRL:
        begin
          next_global_irq_enable  = wr_data[`MFIT_IC_GEN];
          next_grouped_irq_enable = wr_data[`MFIT_IC_GRP_EN];
          next_interval0_enable   = wr_data[`MFIT_IC_TB0_EN];
          next_interval1_enable   = wr_data[`MFIT_IC_TB1_EN];
          next_grouped_irq_flag   = wr_data[`MFIT_IC_GRP_FLAG];
          next_interval0_flag     = wr_data[`MFIT_IC_TB0_FLAG];
          next_interval1_flag     = wr_data[`MFIT_IC_TB1_FLAG];
        end
        `MFIT_OFS_SUBEN:   next_sub_en   = mfit_pkg::mfit_sub_s'(wr_data[4:0]);
        // software clears sub flags itself, or pre-sets them to mask wake
        `MFIT_OFS_SUBFLAG: next_sub_flag = mfit_pkg::mfit_sub_s'(wr_data[4:0]);
        default: ;
      endcase
    end
    if (took)
    begin
      next_global_irq_enable = 1'b0;
      unique case (irq_vec)
        mfit_pkg::VEC_GROUPED: next_grouped_irq_flag = 1'b0;
        mfit_pkg::VEC_TB0:     next_interval0_flag   = 1'b0;
        mfit_pkg::VEC_TB1:     next_interval1_flag   = 1'b0;
        mfit_pkg::VEC_NONE:    ;
      endcase
    end
    next_sub_flag         = next_sub_flag | ev_sub;
    next_grouped_irq_flag = next_grouped_irq_flag | grp_ev;
    next_interval0_flag   = next_interval0_flag | ovf0;
    next_interval1_flag   = next_interval1_flag | ovf1;
  end

  // ---------------------------------------------------------------------------
  // vector request, wake and read data
  // ---------------------------------------------------------------------------
  // request drops the cycle after acceptance so one call is made per service
  always_comb
  begin
    pend_grp      = global_irq_enable && grouped_irq_enable && grouped_irq_flag;
    pend_tb0      = global_irq_enable && interval0_enable && interval0_flag;
    pend_tb1      = global_irq_enable && interval1_enable && interval1_flag;
    next_irq_req  = 1'b0;
    next_irq_vec  = mfit_pkg::VEC_NONE;
    next_irq_addr = 8'h00;
    if (!stack_full && !took)
    begin
      next_irq_req = pend_grp || pend_tb0 || pend_tb1;
      if (pend_grp)
      begin
        next_irq_vec  = mfit_pkg::VEC_GROUPED;
        next_irq_addr = `MFIT_VEC_GROUPED;
      end
      else if (pend_tb0)
      begin
        next_irq_vec  = mfit_pkg::VEC_TB0;
        next_irq_addr = VEC_TB0_ADDR;
      end
      else if (pend_tb1)
      begin
        next_irq_vec  = mfit_pkg::VEC_TB1;
        next_irq_addr = VEC_TB1_ADDR;
      end
    end
    old_flags     = {grouped_irq_flag, interval0_flag, interval1_flag, sub_flag};
    new_flags     = {next_grouped_irq_flag, next_interval0_flag, next_interval1_flag,
                     next_sub_flag};
    // interrupt enables play no part in wake-up; sub enables only through the grouped flag
    next_wake_req = halted && |(new_flags & ~old_flags);
    next_rd_data  = 8'h00;
    if (rd_en)
    begin
      unique case (addr)
        `MFIT_OFS_TBCTRL:  next_rd_data = timebase_control;
        `MFIT_OFS_IRQCTRL: next_rd_data = {1'b0, interval1_flag, interval0_flag,
                                           grouped_irq_flag, interval1_enable,
                                           interval0_enable, grouped_irq_enable,
                                           global_irq_enable};
        `MFIT_OFS_SUBEN:   next_rd_data = {3'b000, sub_en};
        `MFIT_OFS_SUBFLAG: next_rd_data = {3'b000, sub_flag};
        default:           next_rd_data = 8'h00;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      timebase_control       <= `MFIT_TBC_RESET;
      global_irq_enable      <= 1'b0;
      grouped_irq_enable     <= 1'b0;
      interval0_enable       <= 1'b0;
      interval1_enable       <= 1'b0;
      grouped_irq_flag       <= 1'b0;
      interval0_flag         <= 1'b0;
      interval1_flag         <= 1'b0;
      sub_en                 <= '0;
      sub_flag               <= '0;
      irq_vec                <= mfit_pkg::VEC_NONE;
      irq_req                <= 1'b0;
      irq_addr               <= 8'h00;
      wake_req               <= 1'b0;
      rd_data                <= 8'h00;
      slow_crystal_low_power <= 1'b0;
      periph_prev            <= 1'b1;
      cmp_prev               <= 2'b00;
      ick_prev               <= 1'b0;
      pre_cnt                <= 2'd0;
    end
    else
    begin
      timebase_control       <= next_timebase_control;
      global_irq_enable      <= next_global_irq_enable;
      grouped_irq_enable     <= next_grouped_irq_enable;
      interval0_enable       <= next_interval0_enable;
      interval1_enable       <= next_interval1_enable;
      grouped_irq_flag       <= next_grouped_irq_flag;
      interval0_flag         <= next_interval0_flag;
      interval1_flag         <= next_interval1_flag;
      sub_en                 <= next_sub_en;
      sub_flag               <= next_sub_flag;
      irq_vec                <= next_irq_vec;
      irq_req                <= next_irq_req;
      irq_addr               <= next_irq_addr;
      wake_req               <= next_wake_req;
      rd_data                <= next_rd_data;
      slow_crystal_low_power <= next_timebase_control[`MFIT_TBC_LOWPWR];
      periph_prev            <= src.periph_edge_input;
      cmp_prev               <= src.comparator_out;
      ick_prev               <= interval_clock;
      pre_cnt                <= next_pre_cnt;
    end
  end

  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  property p_conv_sets;
    @(posedge ref_clk) disable iff (!nrst) src.conv_done |=> sub_flag.conv_done;
  endproperty
  a_conv_sets: assert property (p_conv_sets)
    else $error("conversion done did not set its flag");

  property p_grp_addr;
    @(posedge ref_clk) disable iff (!nrst)
    (irq_req && irq_vec == mfit_pkg::VEC_GROUPED) |-> irq_addr == 8'h18;
  endproperty
  a_grp_addr: assert property (p_grp_addr)
    else $error("grouped request not at address 18H");

  property p_sub_kept;
    @(posedge ref_clk) disable iff (!nrst)
    (irq_req && irq_ack && irq_vec == mfit_pkg::VEC_GROUPED && !wr_en)
      |=> (sub_flag == ($past(sub_flag) | $past(ev_sub))) && !global_irq_enable;
  endproperty
  a_sub_kept: assert property (p_sub_kept)
    else $error("grouped service disturbed sub flags or kept global enable");

  property p_tb_sets;
    @(posedge ref_clk) disable iff (!nrst) ovf0 |=> interval0_flag;
  endproperty
  a_tb_sets: assert property (p_tb_sets)
    else $error("interval0 overflow did not set its flag");

  property p_tb_clear;
    @(posedge ref_clk) disable iff (!nrst)
    (irq_req && irq_ack && irq_vec == mfit_pkg::VEC_TB0 && !ovf0 && !wr_en)
      |=> !interval0_flag && !irq_req;
  endproperty
  a_tb_clear: assert property (p_tb_clear)
    else $error("interval0 service did not clear flag");

  property p_stack_gate;
    @(posedge ref_clk) disable iff (!nrst) $rose(irq_req) |-> !$past(stack_full);
  endproperty
  a_stack_gate: assert property (p_stack_gate)
    else $error("request raised while stack full");

  property p_periph_edge;
    @(posedge ref_clk) disable iff (!nrst)
    $fell(src.periph_edge_input) |=> sub_flag.periph_edge;
  endproperty
  a_periph_edge: assert property (p_periph_edge)
    else $error("falling peripheral edge missed");

  property p_cmp_change;
    @(posedge ref_clk) disable iff (!nrst)
    (src.comparator_out != $past(src.comparator_out)) |=> sub_flag.comparator;
  endproperty
  a_cmp_change: assert property (p_cmp_change)
    else $error("comparator change missed");

  property p_wake;
    @(posedge ref_clk) disable iff (!nrst)
    ($past(halted) && $rose(sub_flag.conv_done)) |-> wake_req;
  endproperty
  a_wake: assert property (p_wake)
    else $error("flag rise did not wake the core");

endmodule : mfit_irq_top

/* shared/mfit_params.svh */
`ifndef MFIT_PARAMS_SVH
`define MFIT_PARAMS_SVH

// ---------------------------------------------------------------------------
// register offsets (byte addresses on the plain register port)
// ---------------------------------------------------------------------------
`define MFIT_OFS_TBCTRL      8'h00
`define MFIT_OFS_IRQCTRL     8'h01
`define MFIT_OFS_SUBEN       8'h02
`define MFIT_OFS_SUBFLAG     8'h03

// ---------------------------------------------------------------------------
// timebase_control fields and reset value
// ---------------------------------------------------------------------------
`define MFIT_TBC_RESET       8'h37
`define MFIT_TBC_RUN         7
`define MFIT_TBC_CKSEL       6
`define MFIT_TBC_P1_HI       5
`define MFIT_TBC_P1_LO       4
`define MFIT_TBC_LOWPWR      3
`define MFIT_TBC_P0_HI       2
`define MFIT_TBC_P0_LO       0

// ---------------------------------------------------------------------------
// irq control register fields
// ---------------------------------------------------------------------------
`define MFIT_IC_GEN          0
`define MFIT_IC_GRP_EN       1
`define MFIT_IC_TB0_EN       2
`define MFIT_IC_TB1_EN       3
`define MFIT_IC_GRP_FLAG     4
`define MFIT_IC_TB0_FLAG     5
`define MFIT_IC_TB1_FLAG     6

// ---------------------------------------------------------------------------
// vectors and timing counts
// ---------------------------------------------------------------------------
`define MFIT_VEC_GROUPED     8'h18
`define MFIT_SYS_DIV         4
`define MFIT_TB0_BASE_LOG2   8
`define MFIT_TB1_BASE_LOG2   12
`define MFIT_TB_CNT_W        15

`endif

/* shared/mfit_pkg.sv */
package mfit_pkg;

  // ---------------------------------------------------------------------------
  // vector selection presented to the core
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    VEC_NONE,
    VEC_GROUPED,
    VEC_TB0,
    VEC_TB1
  } mfit_vec_e;

  // grouped sub-source bits, used for flags and enables alike
  typedef struct packed {
    logic low_supply;
    logic memory_cycle;
    logic comparator;
    logic periph_edge;
    logic conv_done;
  } mfit_sub_s;

  // raw on-chip source signals
  typedef struct packed {
    logic       conv_done;
    logic       memory_cycle_done;
    logic       low_supply;
    logic       periph_edge_input;
    logic [1:0] comparator_out;
  } mfit_src_s;

endpackage : mfit_pkg

/* testbench/mfit_core_model.sv */
`timescale 1ns/1ps

// ---------------------------------------------------------------------------
// core side: takes a pending vector after a chosen number of cycles
// ---------------------------------------------------------------------------
module mfit_core_model (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       nrst,
  // handshake
  input  wire logic       irq_req,
  input  wire logic [3:0] lag,
  output logic            irq_ack
);
  logic [3:0] cnt;

  // ack one cycle only, never without a request in front of it
  always_ff @(posedge ref_clk)
  begin
    if (!nrst || !irq_req || irq_ack)
    begin
      irq_ack <= 1'b0;
      cnt     <= 4'h0;
    end
    else if (cnt == lag)
      irq_ack <= 1'b1;
    else
      cnt <= cnt + 4'h1;
  end
endmodule : mfit_core_model

/* testbench/multifunction_irq_timebase_tb_top.sv */
`timescale 1ns/1ps
`include "mfit_params.svh"

module multifunction_irq_timebase_tb_top;
  // ---------------------------------------------------------------------------
  // pins and bookkeeping
  // ---------------------------------------------------------------------------
  logic                ref_clk, nrst, wr_en, rd_en, stack_full, halted;
  logic                interval_clock, irq_req, irq_ack, wake_req, slow_crystal_low_power;
  logic [7:0]          addr, wr_data, rd_data, irq_addr;
  logic [3:0]          lag;
  mfit_pkg::mfit_src_s src;
  int                  miscompares, cmp_count, n;
  integer              seed;

  mfit_irq_top #(.VEC_TB0_ADDR(8'h1C), .VEC_TB1_ADDR(8'h20)) dut (.ref_clk(ref_clk),
    .nrst(nrst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
    .rd_data(rd_data), .src(src), .interval_clock(interval_clock), .stack_full(stack_full),
    .irq_ack(irq_ack), .halted(halted), .irq_req(irq_req), .irq_addr(irq_addr),
    .wake_req(wake_req), .slow_crystal_low_power(slow_crystal_low_power));
  mfit_core_model core (.ref_clk(ref_clk), .nrst(nrst), .irq_req(irq_req), .lag(lag),
    .irq_ack(irq_ack));

  // 20 MHz clock; dedicated interval clock wanders at random
  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) interval_clock <= 1'($random(seed));

  // ---------------------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------------------
  task automatic end_sim;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_sim

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask : chk

  // idle edge after the strobe so a following call never re-drives it in one step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr    <= a;
    wr_data <= d;
    wr_en   <= 1'b1;
    @(posedge ref_clk);
    wr_en <= 1'b0;
    @(posedge ref_clk);
  endtask : wr

  // read data stand only in the cycle after the strobe; read at the edge, before it updates
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp, input string what);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    @(posedge ref_clk);
    chk(what, rd_data, exp);
  endtask : rdc

  // bounded wait for the request level; outputs read at the edge keep drivers aligned
  task automatic wait_req(input logic lvl, input int lim);
    n = 0;
    while (irq_req !== lvl && n < lim)
    begin
      @(posedge ref_clk);
      n++;
    end
  endtask : wait_req

  // one event on sub-source i; for i=1 the pin falls then rises back, which must not count
  task automatic fire(input int i);
    case (i)
      0: src.conv_done <= 1'b1;
      1: src.periph_edge_input <= 1'b0;
      2: src.comparator_out <= src.comparator_out ^ (2'b01 << ($random(seed) & 1));
      3: src.memory_cycle_done <= 1'b1;
      default: src.low_supply <= 1'b1;
    endcase
    @(posedge ref_clk);
    src <= mfit_pkg::mfit_src_s'({3'b000, 1'b1, src.comparator_out});
  endtask : fire

  task automatic count_wake;
    n = 0;
    repeat (6)
    begin
      @(posedge ref_clk);
      n += int'(wake_req === 1'b1);
    end
  endtask : count_wake

  // ---------------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------------
  initial
  begin
    seed = 32'hF3E18AB6;
    {miscompares, cmp_count, wr_en, rd_en, addr, wr_data, stack_full, halted, lag} = '0;
    nrst = 1'b0;
    src  = mfit_pkg::mfit_src_s'(6'h04);
    repeat (2) @(posedge ref_clk);
    nrst <= 1'b1;
    @(posedge ref_clk);
    rdc(`MFIT_OFS_TBCTRL, 8'h37, "tbc_reset");
    wr(8'h0F, 8'hFF);
    rdc(8'h0F, 8'h00, "unmapped");
    // every grouped sub-source: blocked by full stack, then vectored and serviced
    for (int i = 0; i < 5; i++)
    begin
      wr(`MFIT_OFS_SUBFLAG, 8'h00);
      wr(`MFIT_OFS_SUBEN, 8'h01 << i);
      wr(`MFIT_OFS_IRQCTRL, 8'h03);
      lag        <= 4'($random(seed));
      stack_full <= 1'b1;
      fire(i);
      repeat (3) @(posedge ref_clk);
      chk("req_stack_full", irq_req, 1'b0);
      stack_full <= 1'b0;
      wait_req(1'b1, 20);
      chk("grp_req", irq_req, 1'b1);
      chk("grp_vec", irq_addr, 8'h18);
      wait_req(1'b0, 40);
      rdc(`MFIT_OFS_IRQCTRL, 8'h02, "ctrl_serviced");
      rdc(`MFIT_OFS_SUBFLAG, 8'h01 << i, "sub_kept");
    end
    // global enable now clear: an enabled low-supply event must not vector
    fire(4);
    repeat (4) @(posedge ref_clk);
    chk("req_gated", irq_req, 1'b0);
    // interval 0 at its shortest: 256 ticks of sys/4 gives 1024 clocks
    wr(`MFIT_OFS_TBCTRL, 8'hC8);
    wr(`MFIT_OFS_IRQCTRL, 8'h05);
    chk("low_power", slow_crystal_low_power, 1'b1);
    wait_req(1'b1, 1100);
    chk("tb0_period", int'(n >= 1016 && n <= 1032), 1);
    chk("tb0_vec", irq_addr, 8'h1C);
    wait_req(1'b0, 40);
    rdc(`MFIT_OFS_IRQCTRL, 8'h04, "tb0_serviced");
    // interval 1 code 00: 4096 ticks from the shared start
    wr(`MFIT_OFS_IRQCTRL, 8'h09);
    wait_req(1'b1, 17000);
    chk("tb1_period", int'(n >= 15200 && n <= 15400), 1);
    chk("tb1_vec", irq_addr, 8'h20);
    wait_req(1'b0, 40);
    // dedicated clock from a cleared counter; the random pin rises about once in four
    wr(`MFIT_OFS_TBCTRL, 8'h00);
    chk("low_power_off", slow_crystal_low_power, 1'b0);
    wr(`MFIT_OFS_IRQCTRL, 8'h05);
    wr(`MFIT_OFS_TBCTRL, 8'h80);
    wait_req(1'b1, 3000);
    chk("tb0_ded_clock", int'(n >= 800 && n <= 1300), 1);
    chk("tb0_ded_vec", irq_addr, 8'h1C);
    wait_req(1'b0, 40);
    // stopped dividers raise nothing
    wr(`MFIT_OFS_TBCTRL, 8'h40);
    wr(`MFIT_OFS_IRQCTRL, 8'h00);
    repeat (1100) @(posedge ref_clk);
    rdc(`MFIT_OFS_IRQCTRL, 8'h00, "tb_stopped");
    // wake with every enable off, then masked by a pre-set flag
    halted <= 1'b1;
    wr(`MFIT_OFS_SUBEN, 8'h00);
    wr(`MFIT_OFS_SUBFLAG, 8'h00);
    fire(0);
    count_wake;
    chk("wake_once", n, 1);
    fire(0);
    count_wake;
    chk("wake_masked", n, 0);
    end_sim;
  end

  // hang guard, about twice the expected run
  initial
  begin
    #2000000;
    miscompares++;
    end_sim;
  end
endmodule : multifunction_irq_timebase_tb_top
